// ===== logic/tcs_timer_map.vh
// Purpose: Shared constants of the timer clock and clear select block
// Assumes: Included by bare name from the design files
// Notes:   Definitions only
`ifndef TCS_TIMER_MAP_VH
`define TCS_TIMER_MAP_VH

// Control byte field positions
`define TCS_CLR_MSB      7
`define TCS_CLR_LSB      5
`define TCS_EDGE_MSB     4
`define TCS_EDGE_LSB     3
`define TCS_PSC_MSB      2
`define TCS_PSC_LSB      0
`define TCS_CTRL_RESET   8'h00

// Clear select codes
`define TCS_CLR_NONE     3'h0
`define TCS_CLR_A        3'h1
`define TCS_CLR_B        3'h2
`define TCS_CLR_SYNC     3'h3
`define TCS_CLR_NONE2    3'h4
`define TCS_CLR_C        3'h5
`define TCS_CLR_D        3'h6
`define TCS_CLR_SYNC2    3'h7

// Prescaler select codes
`define TCS_PSC_DIV1     3'h0
`define TCS_PSC_DIV4     3'h1
`define TCS_PSC_DIV16    3'h2
`define TCS_PSC_DIV64    3'h3
`define TCS_PSC_EXTA     3'h4
`define TCS_PSC_EXTB     3'h5
`define TCS_PSC_CODE6    3'h6
`define TCS_PSC_CODE7    3'h7

// Divider shift counts (division ratio is two to this power)
`define TCS_SH_DIV4      4'd2
`define TCS_SH_DIV16     4'd4
`define TCS_SH_DIV64     4'd6
`define TCS_SH_DIV256    4'd8
`define TCS_SH_DIV1024   4'd10
`define TCS_PRE_WIDTH    10
`define TCS_CNT_WIDTH    16

`endif

// ===== logic/tcs_channel.v
// Purpose: One timer channel counter with its clearing source select
// Assumes: Count tick and direction come from the clock select logic
// Notes:   Clear has priority over counting in the same cycle
`timescale 1ns/1ps
`default_nettype none
`include "tcs_timer_map.vh"

module tcs_channel (
  // Clock and reset
  input  wire        clk_i,
  input  wire        nrst_i,
  // Counting
  input  wire        tick_i,
  input  wire        down_i,
  // Clear selection and sources
  input  wire [2:0]  clear_select_i,
  input  wire        match_a_i,
  input  wire        match_b_i,
  input  wire        match_c_i,
  input  wire        match_d_i,
  input  wire        buf_c_i,
  input  wire        buf_d_i,
  input  wire        sync_clear_i,
  // Results
  output wire        own_clear_o,
  output wire        clear_o,
  output reg  [15:0] timer_count_o
);

  reg own_clear;
  reg sync_sel;

  always @* begin
    own_clear = 1'b0;
    sync_sel  = 1'b0;
    case (clear_select_i)
      `TCS_CLR_NONE:  own_clear = 1'b0;                  // RQ1
      `TCS_CLR_NONE2: own_clear = 1'b0;                  // RQ1
      `TCS_CLR_A:     own_clear = match_a_i;             // RQ2
      `TCS_CLR_B:     own_clear = match_b_i;             // RQ3
      `TCS_CLR_C:     own_clear = match_c_i & ~buf_c_i;  // RQ6 RQ8
      `TCS_CLR_D:     own_clear = match_d_i & ~buf_d_i;  // RQ7 RQ8
      `TCS_CLR_SYNC:  sync_sel  = 1'b1;                  // RQ4
      `TCS_CLR_SYNC2: sync_sel  = 1'b1;                  // RQ4
      default:        own_clear = 1'b0;
    endcase
  end

  assign own_clear_o = own_clear;
  assign clear_o     = own_clear | (sync_sel & sync_clear_i); // RQ4

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      timer_count_o <= 16'h0000;
    end else if (clear_o) begin
      timer_count_o <= 16'h0000;
    end else if (tick_i) begin
      if (down_i) begin
        timer_count_o <= timer_count_o - 16'h0001;
      end else begin
        timer_count_o <= timer_count_o + 16'h0001;
      end
    end
  end

endmodule

`default_nettype wire

// ===== logic/tcs_timer.v
// Purpose: Counter clock source and clearing source select, three channels
// Assumes: All inputs except the external clock pins are on clk_i
// Notes:   External pins are synchronised and edge detected before use
`timescale 1ns/1ps
`default_nettype none
`include "tcs_timer_map.vh"

// What this block does
// RQ1: Channel 0 clear select 000 or 100 disables counter clearing.
// RQ2: Clear select 001 clears the counter on register A match or capture.
// RQ3: Clear select 010 clears the counter on register B match or capture.
// RQ4: Select 011 (or 111 on channel 0) clears with another synced channel.
// RQ5: A channel takes part in synchronous clearing only with its sync bit set.
// RQ6: Channel 0 select 101 clears on register C match or capture.
// RQ7: Channel 0 select 110 clears on register D match or capture.
// RQ8: Register C or D in buffer use never clears the counter.
// RQ9: Channels 1 and 2 top clear bit reads zero and ignores writes.
// RQ10: Prescale 000 to 011 counts on system clock over 1, 4, 16, 64.
// RQ11: Prescale 100 counts external pin A edges, 101 external pin B.
// RQ12: Channel 0 prescale 110 counts pin C, 111 counts pin D.
// RQ13: Channel 1 prescale 110 divides by 256; software never writes 111.
// RQ14: Channel 2 prescale 110 counts pin C, 111 divides by 1024.
// RQ15: Channel 1 phase counting mode overrides the prescale setting.
// RQ16: Both edges halve internal period; divide by 1 ignores edge setting.
// RQ17: External pins are synchronised and edge detected, one count per edge.
module tcs_timer (
  // Clock and reset
  input  wire        clk_i,
  input  wire        nrst_i,
  // Control bytes: clear select, edge select, prescale select
  input  wire [7:0]  ctrl0_i,
  input  wire [7:0]  ctrl1_i,
  input  wire [7:0]  ctrl2_i,
  // Synchronous operation enables, one bit per channel
  input  wire [2:0]  sync_register_i,
  // Buffer operation of channel 0 registers C and D
  input  wire        buf_c0_i,
  input  wire        buf_d0_i,
  // Compare match or input capture events, A and B one bit per channel, C and D channel 0 only
  input  wire [2:0]  match_a_i,
  input  wire [2:0]  match_b_i,
  input  wire        match_c0_i,
  input  wire        match_d0_i,
  // Channel 1 phase counting
  input  wire        phase_mode1_i,
  input  wire        phase_tick1_i,
  input  wire        phase_down1_i,
  // External clock pins
  input  wire        ext_clk_pin_a_i,
  input  wire        ext_clk_pin_b_i,
  input  wire        ext_clk_pin_c_i,
  input  wire        ext_clk_pin_d_i,
  // Control readback
  output wire [7:0]  ctrl0_o,
  output wire [7:0]  ctrl1_o,
  output wire [7:0]  ctrl2_o,
  // Counters and clear pulses
  output wire [15:0] timer_count0_o,
  output wire [15:0] timer_count1_o,
  output wire [15:0] timer_count2_o,
  output wire [2:0]  clear_o
);

  reg  [`TCS_PRE_WIDTH-1:0] pre_cnt;
  reg  [3:0]                pin_meta;
  reg  [3:0]                pin_sync;
  reg  [3:0]                pin_last;
  wire [3:0]                pin_rise;
  wire [3:0]                pin_fall;
  wire [2:0]                tick;
  wire [2:0]                own_clear;
  wire [2:0]                sync_clear;
  wire [2:0]                clr_sel1;
  wire [2:0]                clr_sel2;
  wire [7:0]                ctrl1_eff;
  wire [7:0]                ctrl2_eff;

  // Edge of a prescaled clock whose period is two to the power sh cycles
  function int_tick;
    input [`TCS_PRE_WIDTH-1:0] c;
    input [3:0]                sh;
    input [1:0]                eg;
    reg   [`TCS_PRE_WIDTH-1:0] mask;
    reg   [`TCS_PRE_WIDTH-1:0] low;
    reg                        rise;
    reg                        fall;
    begin
      mask = ~({`TCS_PRE_WIDTH{1'b1}} << sh);
      low  = c & mask;
      rise = (low == (mask >> 1));
      fall = (low == mask);
      if (eg[1]) begin
        int_tick = rise | fall; // RQ16
      end else if (eg[0]) begin
        int_tick = fall;
      end else begin
        int_tick = rise;
      end
    end
  endfunction

  // External pin edge according to the edge setting
  function ext_tick;
    input       r;
    input       f;
    input [1:0] eg;
    begin
      if (eg[1]) begin
        ext_tick = r | f;
      end else if (eg[0]) begin
        ext_tick = f;
      end else begin
        ext_tick = r;
      end
    end
  endfunction

  // Clock source select for one channel
  function sel_tick;
    input [1:0]                ch;
    input [2:0]                psc;
    input [1:0]                eg;
    input [`TCS_PRE_WIDTH-1:0] c;
    input [3:0]                r;
    input [3:0]                f;
    begin
      case (psc)
        `TCS_PSC_DIV1:  sel_tick = 1'b1;                            // RQ16
        `TCS_PSC_DIV4:  sel_tick = int_tick(c, `TCS_SH_DIV4, eg);   // RQ10
        `TCS_PSC_DIV16: sel_tick = int_tick(c, `TCS_SH_DIV16, eg);  // RQ10
        `TCS_PSC_DIV64: sel_tick = int_tick(c, `TCS_SH_DIV64, eg);  // RQ10
        `TCS_PSC_EXTA:  sel_tick = ext_tick(r[0], f[0], eg);        // RQ11
        `TCS_PSC_EXTB:  sel_tick = ext_tick(r[1], f[1], eg);        // RQ11
        `TCS_PSC_CODE6: begin
          if (ch == 2'd1) begin
            sel_tick = int_tick(c, `TCS_SH_DIV256, eg);             // RQ13
          end else begin
            sel_tick = ext_tick(r[2], f[2], eg);                    // RQ12 RQ14
          end
        end
        `TCS_PSC_CODE7: begin
          if (ch == 2'd0) begin
            sel_tick = ext_tick(r[3], f[3], eg);                    // RQ12
          end else if (ch == 2'd2) begin
            sel_tick = int_tick(c, `TCS_SH_DIV1024, eg);            // RQ14
          end else begin
            sel_tick = 1'b0;                                        // RQ13
          end
        end
        default: sel_tick = 1'b0;
      endcase
    end
  endfunction

  // Free running prescaler shared by all channels
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      pre_cnt <= {`TCS_PRE_WIDTH{1'b0}};
    end else begin
      pre_cnt <= pre_cnt + {{(`TCS_PRE_WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // Two stage synchroniser, then a third stage for edge detection
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      pin_last <= 4'h0;
    end else begin
      pin_meta <= {ext_clk_pin_d_i, ext_clk_pin_c_i,
                   ext_clk_pin_b_i, ext_clk_pin_a_i};  // RQ17
      pin_sync <= pin_meta;                            // RQ17
      pin_last <= pin_sync;                            // RQ17
    end
  end

  assign pin_rise = pin_sync & ~pin_last;  // RQ17
  assign pin_fall = ~pin_sync & pin_last;  // RQ17

  assign tick[0] = sel_tick(2'd0, ctrl0_i[`TCS_PSC_MSB:`TCS_PSC_LSB],
                            ctrl0_i[`TCS_EDGE_MSB:`TCS_EDGE_LSB],
                            pre_cnt, pin_rise, pin_fall);
  // Phase counting replaces the prescaled source on channel 1
  assign tick[1] = phase_mode1_i ? phase_tick1_i :           // RQ15
                   sel_tick(2'd1, ctrl1_i[`TCS_PSC_MSB:`TCS_PSC_LSB],
                            ctrl1_i[`TCS_EDGE_MSB:`TCS_EDGE_LSB],
                            pre_cnt, pin_rise, pin_fall);
  assign tick[2] = sel_tick(2'd2, ctrl2_i[`TCS_PSC_MSB:`TCS_PSC_LSB],
                            ctrl2_i[`TCS_EDGE_MSB:`TCS_EDGE_LSB],
                            pre_cnt, pin_rise, pin_fall);

  // Channels 1 and 2 have no top clear bit
  assign ctrl1_eff = {1'b0, ctrl1_i[6:0]};  // RQ9
  assign ctrl2_eff = {1'b0, ctrl2_i[6:0]};  // RQ9
  assign clr_sel1  = ctrl1_eff[`TCS_CLR_MSB:`TCS_CLR_LSB];
  assign clr_sel2  = ctrl2_eff[`TCS_CLR_MSB:`TCS_CLR_LSB];
  assign ctrl0_o   = ctrl0_i;
  assign ctrl1_o   = ctrl1_eff;
  assign ctrl2_o   = ctrl2_eff;

  // A synced channel follows own clears of the other synced channels
  assign sync_clear[0] = sync_register_i[0] &
                         |(own_clear[2:1] & sync_register_i[2:1]); // RQ4 RQ5
  assign sync_clear[1] = sync_register_i[1] &
                         ((own_clear[0] & sync_register_i[0]) |
                          (own_clear[2] & sync_register_i[2]));    // RQ4 RQ5
  assign sync_clear[2] = sync_register_i[2] &
                         |(own_clear[1:0] & sync_register_i[1:0]); // RQ4 RQ5

  tcs_channel u_ch0 (
    .clk_i          (clk_i),
    .nrst_i         (nrst_i),
    .tick_i         (tick[0]),
    .down_i         (1'b0),
    .clear_select_i (ctrl0_i[`TCS_CLR_MSB:`TCS_CLR_LSB]),
    .match_a_i      (match_a_i[0]),
    .match_b_i      (match_b_i[0]),
    .match_c_i      (match_c0_i),
    .match_d_i      (match_d0_i),
    .buf_c_i        (buf_c0_i),
    .buf_d_i        (buf_d0_i),
    .sync_clear_i   (sync_clear[0]),
    .own_clear_o    (own_clear[0]),
    .clear_o        (clear_o[0]),
    .timer_count_o  (timer_count0_o)
  );

  tcs_channel u_ch1 (
    .clk_i          (clk_i),
    .nrst_i         (nrst_i),
    .tick_i         (tick[1]),
    .down_i         (phase_mode1_i & phase_down1_i),
    .clear_select_i (clr_sel1),
    .match_a_i      (match_a_i[1]),
    .match_b_i      (match_b_i[1]),
    .match_c_i      (1'b0),
    .match_d_i      (1'b0),
    .buf_c_i        (1'b0),
    .buf_d_i        (1'b0),
    .sync_clear_i   (sync_clear[1]),
    .own_clear_o    (own_clear[1]),
    .clear_o        (clear_o[1]),
    .timer_count_o  (timer_count1_o)
  );

  tcs_channel u_ch2 (
    .clk_i          (clk_i),
    .nrst_i         (nrst_i),
    .tick_i         (tick[2]),
    .down_i         (1'b0),
    .clear_select_i (clr_sel2),
    .match_a_i      (match_a_i[2]),
    .match_b_i      (match_b_i[2]),
    .match_c_i      (1'b0),
    .match_d_i      (1'b0),
    .buf_c_i        (1'b0),
    .buf_d_i        (1'b0),
    .sync_clear_i   (sync_clear[2]),
    .own_clear_o    (own_clear[2]),
    .clear_o        (clear_o[2]),
    .timer_count_o  (timer_count2_o)
  );

endmodule

`default_nettype wire

// ===== verif/tcs_timer_sva.sv
// Purpose: Port assertions for the timer clock and clear select block
// Assumes: Inputs settle between clock edges
// Notes:   Clear strobes are same cycle, counters follow one cycle later
`timescale 1ns/1ps
`default_nettype none
module tcs_timer_chk (
  // Watched ports
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic [7:0]  ctrl0_i,
  input wire logic [7:0]  ctrl1_i,
  input wire logic [7:0]  ctrl2_i,
  input wire logic [2:0]  sync_register_i,
  input wire logic        buf_c0_i,
  input wire logic [2:0]  match_a_i,
  input wire logic        match_c0_i,
  input wire logic        phase_mode1_i,
  input wire logic        phase_tick1_i,
  input wire logic [7:0]  ctrl1_o,
  input wire logic [15:0] timer_count0_o,
  input wire logic [15:0] timer_count1_o,
  input wire logic [15:0] timer_count2_o,
  input wire logic [2:0]  clear_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_ro_bit: assert property (ctrl1_o == {1'b0, ctrl1_i[6:0]})
    else $error("channel 1 top clear bit not masked");
  a_clear_off: assert property (ctrl0_i[6:5] == 2'h0 |-> !clear_o[0])
    else $error("channel 0 cleared while clearing disabled");
  a_clear_a: assert property
    (ctrl0_i[7:5] == 3'h1 && match_a_i[0] |-> clear_o[0])
    else $error("register A event did not clear channel 0");
  a_clear_c: assert property
    (ctrl0_i[7:5] == 3'h5 && match_c0_i && !buf_c0_i |-> clear_o[0])
    else $error("register C event did not clear channel 0");
  a_buf_block: assert property
    (ctrl0_i[7:5] == 3'h5 && buf_c0_i |-> !clear_o[0])
    else $error("buffered register C cleared channel 0");
  a_sync_clear: assert property
    (ctrl1_i[6:5] == 2'h3 && sync_register_i[1:0] == 2'h3 &&
     ctrl0_i[7:5] == 3'h1 && match_a_i[0] |-> clear_o[1])
    else $error("synchronous clear missed on channel 1");
  a_no_sync: assert property
    (ctrl2_i[6:5] == 2'h3 && !sync_register_i[2] |-> !clear_o[2])
    else $error("unsynced channel 2 cleared");
  a_count_clr: assert property (clear_o[0] |=> timer_count0_o == 16'h0)
    else $error("channel 0 counter not zero after clear");
  a_div1_step: assert property
    (ctrl2_i[2:0] == 3'h0 && !clear_o[2] |=>
     timer_count2_o == $past(timer_count2_o) + 16'h1)
    else $error("channel 2 missed a divide by one count");
  a_code7_stop: assert property
    (ctrl1_i[2:0] == 3'h7 && !phase_mode1_i && !clear_o[1] |=>
     $stable(timer_count1_o))
    else $error("channel 1 counted on the prohibited setting");
  a_phase_hold: assert property
    (phase_mode1_i && !phase_tick1_i && !clear_o[1] |=>
     $stable(timer_count1_o))
    else $error("channel 1 counted without a phase step");
endmodule
bind tcs_timer tcs_timer_chk chk (.clk_i, .nrst_i, .ctrl0_i, .ctrl1_i,
  .ctrl2_i, .sync_register_i, .buf_c0_i, .match_a_i, .match_c0_i,
  .phase_mode1_i, .phase_tick1_i, .ctrl1_o, .timer_count0_o,
  .timer_count1_o, .timer_count2_o, .clear_o);
`default_nettype wire

// ===== verif/tcs_pin_src.sv
// Purpose: External clock pin source for the timer bench
// Assumes: go_i lasts one cycle; pins rest low between bursts
// Notes:   A burst is five pulses, four clocks high and four low
`timescale 1ns/1ps
`default_nettype none
module tcs_pin_src (
  // Control
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [1:0] sel_i,
  // Pins
  output wire logic [3:0] pin_o
);
  logic [5:0] left = 6'h00;
  always @(posedge clk_i) begin
    if (go_i)
      left <= 6'h28;
    else if (left != 6'h00)
      left <= left - 6'h01;
  end
  // Pulses wider than the synchroniser needs
  assign pin_o = left[2] ? 4'h1 << sel_i : 4'h0;
endmodule
`default_nettype wire

// ===== verif/tcs_timer_bench.sv
// Purpose: Self-checking bench for the timer clock and clear select block
// Assumes: Inputs change on the falling clock edge
// Notes:   Every measurement starts from a fresh reset
`timescale 1ns/1ps
`default_nettype none
module tcs_timer_bench;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [7:0]  c0 = 8'h00, c1 = 8'h00, c2 = 8'h00;
  logic [2:0]  sync = 3'h0, ma = 3'h0, mb = 3'h0;
  logic        bc = 1'b0, bd = 1'b0, mc = 1'b0, md = 1'b0;
  logic        pm = 1'b0, pt = 1'b0, pd = 1'b0, go = 1'b0, hit;
  logic [1:0]  sel = 2'h0;
  wire  [3:0]  pin;
  wire  [7:0]  r0, r1, r2;
  wire  [15:0] q0, q1, q2;
  wire  [2:0]  clr;
  int          mismatches = 0, n_compared = 0, cyc = 0;
  always #2.5 clk_i = ~clk_i;
  tcs_pin_src src (.clk_i(clk_i), .go_i(go), .sel_i(sel), .pin_o(pin));
  tcs_timer uut (.clk_i(clk_i), .nrst_i(nrst_i), .ctrl0_i(c0),
    .ctrl1_i(c1), .ctrl2_i(c2), .sync_register_i(sync), .buf_c0_i(bc),
    .buf_d0_i(bd), .match_a_i(ma), .match_b_i(mb), .match_c0_i(mc),
    .match_d0_i(md), .phase_mode1_i(pm), .phase_tick1_i(pt),
    .phase_down1_i(pd), .ext_clk_pin_a_i(pin[0]),
    .ext_clk_pin_b_i(pin[1]), .ext_clk_pin_c_i(pin[2]),
    .ext_clk_pin_d_i(pin[3]), .ctrl0_o(r0), .ctrl1_o(r1), .ctrl2_o(r2),
    .timer_count0_o(q0), .timer_count1_o(q1), .timer_count2_o(q2),
    .clear_o(clr));
  task automatic check(input string nm, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    if (mismatches == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic restart(input logic [7:0] a, b, c);
    nrst_i = 1'b0;
    c0 = a;
    c1 = b;
    c2 = c;
    cyc_n(2);
    nrst_i = 1'b1;
  endtask
  // Runs n cycles, optionally with a pin burst, then compares counters
  task automatic run(input logic [7:0] a, b, c, input int n,
                     input logic [15:0] e0, e1, e2, input logic g,
                     input logic [1:0] p);
    restart(a, b, c);
    sel = p;
    go = g;
    cyc_n(1);
    go = 1'b0;
    cyc_n(n - 1);
    check("count0", q0, e0);
    check("count1", q1, e1);
    check("count2", q2, e2);
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 20000) begin
      mismatches++;
      end_of_test;
    end
  end
  initial begin
    run(8'h00, 8'h01, 8'h02, 1024, 1024, 256, 64, 0, 0);
    run(8'h03, 8'h06, 8'h07, 1024, 16, 4, 1, 0, 0);
    run(8'h11, 8'h07, 8'h08, 1024, 512, 0, 1024, 0, 0);
    run(8'h0a, 8'h13, 8'h0b, 1024, 64, 32, 16, 0, 0);
    run(8'h04, 8'h14, 8'h0c, 60, 5, 10, 5, 1, 0);
    run(8'h05, 8'h15, 8'h0d, 60, 5, 10, 5, 1, 1);
    run(8'h06, 8'h07, 8'h16, 60, 5, 0, 10, 1, 2);
    run(8'h07, 8'h04, 8'h06, 60, 5, 0, 0, 1, 3);
    sync = 3'h3;
    for (int b = 0; b < 2; b++)
      for (int c = 0; c < 8; c++)
        for (int s = 0; s < 4; s++) begin
          bc = b[0];
          bd = b[0];
          restart({c[2:0], 5'h00}, 8'he0, 8'he0);
          cyc_n(20);
          hit = s < 2 ? c == s + 1 : c == s + 3 && b == 0;
          {md, mc, mb[0], ma[0]} = 4'h1 << s;
          cyc_n(1);
          check("strobe", {13'h0000, clr}, {14'h0000, hit, hit});
          {md, mc, mb[0], ma[0]} = 4'h0;
          check("clear0", q0, hit ? 16'd0 : 16'd21);
          check("clear1", q1, hit ? 16'd0 : 16'd21);
          check("clear2", q2, 16'd21);
        end
    check("readback0", {8'h00, r0}, 16'h00e0);
    check("readback1", {8'h00, r1}, 16'h0060);
    check("readback2", {8'h00, r2}, 16'h0060);
    // Own clears of channels 1 and 2 reach the synced channel 0
    sync = 3'h7;
    restart(8'h60, 8'h20, 8'hc0);
    cyc_n(20);
    ma = 3'h2;
    cyc_n(1);
    check("sync_strobe", {13'h0000, clr}, 16'h0003);
    ma = 3'h0;
    cyc_n(10);
    mb = 3'h4;
    cyc_n(1);
    check("own_strobe", {13'h0000, clr}, 16'h0005);
    mb = 3'h0;
    check("sync_count0", q0, 16'd0);
    check("own_count1", q1, 16'd11);
    check("own_count2", q2, 16'd0);
    pm = 1'b1;
    restart(8'h00, 8'h00, 8'h00);
    pt = 1'b1;
    cyc_n(3);
    pd = 1'b1;
    cyc_n(1);
    pt = 1'b0;
    pd = 1'b0;
    cyc_n(2);
    check("phase1", q1, 16'd2);
    end_of_test;
  end
endmodule
`default_nettype wire
